/* rtl/dual_adc_map.svh */
// Register offsets, reset values and timing counts of the dual converter control block.
// Assumes inclusion by bare name from rtl/ sources.
`ifndef DUAL_ADC_MAP_SVH
`define DUAL_ADC_MAP_SVH

`define ADC_OFS_CTRL        8'h00
`define ADC_OFS_STATUS      8'h04
`define ADC_OFS_IRQ_STATUS  8'h08
`define ADC_OFS_IRQ_MASK    8'h0c

`define ADC_CTRL_FMT_LSB    0
`define ADC_CTRL_DIV_LSB    2
`define ADC_CTRL_MODE_LSB   4
`define ADC_CTRL_RESET      32'h0000_0000

`define ADC_ST_PINMODE_BIT  0
`define ADC_ST_PD_BIT       1
`define ADC_ST_FMT_LSB      2
`define ADC_ST_DIV_LSB      4
`define ADC_ST_MODE_LSB     6

`define ADC_IRQ_CFGRST_BIT  0
`define ADC_IRQ_OVRA_BIT    1
`define ADC_IRQ_OVRB_BIT    2
`define ADC_IRQ_WIDTH       3

`define ADC_LATENCY_CYCLES  9
`define ADC_PIPE_STAGES     10
`define ADC_HALF_STEPS      (2 * `ADC_LATENCY_CYCLES)
`define ADC_SAMPLE_WIDTH    10
`define ADC_SYNC_WIDTH      8

`endif

/* rtl/dual_adc_pkg.sv */
// Types shared by the dual converter control block.
// Assumes nothing beyond a SystemVerilog compiler.
package dual_adc_pkg;
  typedef enum logic [1:0] {FMT_TWOS, FMT_OFFSET, FMT_GRAY}        fmt_t;
  typedef enum logic [1:0] {DIV_1, DIV_2, DIV_4}                   div_t;
  typedef enum logic [1:0] {MODE_DUAL, MODE_MUX_A, MODE_MUX_B}     mode_t;
endpackage : dual_adc_pkg

/* rtl/delay_if.sv */
// Connection between the control block and its half-cycle delay line.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface delay_if #(parameter int W = 22);
  logic         shift;
  logic [W-1:0] din;
  logic [W-1:0] dout;
  modport user (output shift, output din, input dout);
  modport line (input shift, input din, output dout);
endinterface : delay_if
`default_nettype wire

/* rtl/half_step_delay.sv */
// Delay line that advances one position per half conversion cycle.
// Assumes shift pulses come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module half_step_delay #(
  parameter int DEPTH = 18,
  parameter int W     = 22
) (
  input  wire logic CLK_I,
  input  wire logic RST_N_I,
  delay_if.line     dl
);
  logic [W-1:0] stage_reg [DEPTH];

  // Each shift moves every word one stage on; read data come out of the last register
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_reg[i] <= '0;
      end
    end else if (dl.shift) begin
      stage_reg[0] <= dl.din;
      for (int i = 1; i < DEPTH; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign dl.dout = stage_reg[DEPTH-1];
endmodule : half_step_delay
`default_nettype wire

/* rtl/dual_adc_ctrl.sv */
// Digital side of a dual 10-bit pipelined converter: mode pins, power-down, output buses, AHB-Lite registers.
// Assumes converter core words arrive on CLK_I; pins are asynchronous; one AHB-Lite master.
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "dual_adc_map.svh"

// What this block does
// - Port-enable low selects serial, high selects pins
// - Shared pin: serial data, else output format
// - Shared pin: serial clock, else divider ratio
// - Shared pin: serial select, else bus mode
// - Power-down pin high powers the device down
// - Pin mode: power-down falling edge resets configuration
// - Result appears nine input cycles after sampling
// - Eighteen stages, advancing every half cycle
// - Two ten-bit three-state buses, bit0 LSB
// - Separate over-range flag per channel
// - Separate data clock output per channel
// - Pin mode selects dual or multiplexed bus
module dual_adc_ctrl (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        SERIAL_PORT_ENABLE_N_I,
  input  wire logic        POWER_DOWN_PIN_I,
  input  wire logic        SERIAL_IN_OR_FORMAT_PIN_I,
  input  wire logic        SERIAL_IN_OR_FORMAT_FLOAT_I,
  input  wire logic        SERIAL_CLK_OR_DIVIDER_PIN_I,
  input  wire logic        SERIAL_CLK_OR_DIVIDER_FLOAT_I,
  input  wire logic        PORT_SELECT_OR_OUTPUT_MODE_PIN_I,
  input  wire logic        PORT_SELECT_OR_OUTPUT_MODE_FLOAT_I,
  input  wire logic [9:0]  CORE_SAMPLE_A_I,
  input  wire logic        CORE_OVERRANGE_A_I,
  input  wire logic [9:0]  CORE_SAMPLE_B_I,
  input  wire logic        CORE_OVERRANGE_B_I,
  output logic      [9:0]  SAMPLE_A_O,
  output logic             SAMPLE_A_OE_O,
  output logic             OVERRANGE_FLAG_A_O,
  output logic             DATA_CLOCK_OUT_A_O,
  output logic      [9:0]  SAMPLE_B_O,
  output logic             SAMPLE_B_OE_O,
  output logic             OVERRANGE_FLAG_B_O,
  output logic             DATA_CLOCK_OUT_B_O,
  output logic             SERIAL_DATA_O,
  output logic             SERIAL_CLK_O,
  output logic             SERIAL_SELECT_O,
  output logic             POWERED_DOWN_O,
  output logic             IRQ_O,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O
);
  localparam int SW = `ADC_SAMPLE_WIDTH;
  localparam int DW = 2 * (SW + 1);

  // Three-way strap decode: floating, tied high, tied low
  function automatic logic [1:0] strap(input logic level, input logic floating);
    if (floating) begin
      strap = 2'h2;
    end else if (level) begin
      strap = 2'h1;
    end else begin
      strap = 2'h0;
    end
  endfunction : strap

  // Recode an offset-binary core word into the selected format
  function automatic logic [SW-1:0] recode(input logic [SW-1:0] w, input dual_adc_pkg::fmt_t f);
    unique case (f)
      dual_adc_pkg::FMT_TWOS:   recode = {~w[SW-1], w[SW-2:0]};
      dual_adc_pkg::FMT_OFFSET: recode = w;
      default:                  recode = w ^ (w >> 1);
    endcase
  endfunction : recode

  // Clock cycles per half conversion cycle
  function automatic logic [2:0] half_len(input dual_adc_pkg::div_t d);
    unique case (d)
      dual_adc_pkg::DIV_1: half_len = 3'h1;
      dual_adc_pkg::DIV_2: half_len = 3'h2;
      default:             half_len = 3'h4;
    endcase
  endfunction : half_len

  // Pin synchronisers: a change counts once the second and third stages agree
  logic [`ADC_SYNC_WIDTH-1:0] raw;
  logic [`ADC_SYNC_WIDTH-1:0] sync1_reg;
  logic [`ADC_SYNC_WIDTH-1:0] sync2_reg;
  logic [`ADC_SYNC_WIDTH-1:0] sync3_reg;
  logic [`ADC_SYNC_WIDTH-1:0] pin_reg;
  assign raw = {PORT_SELECT_OR_OUTPUT_MODE_FLOAT_I, SERIAL_CLK_OR_DIVIDER_FLOAT_I,
                SERIAL_IN_OR_FORMAT_FLOAT_I, PORT_SELECT_OR_OUTPUT_MODE_PIN_I,
                SERIAL_CLK_OR_DIVIDER_PIN_I, SERIAL_IN_OR_FORMAT_PIN_I,
                POWER_DOWN_PIN_I, SERIAL_PORT_ENABLE_N_I};

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pin_reg   <= '0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < `ADC_SYNC_WIDTH; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  logic pin_mode;
  logic pd;
  logic pd_prev_reg;
  logic pd_fall;
  assign pin_mode = pin_reg[0];
  assign pd       = pin_reg[1];
  assign pd_fall  = pd_prev_reg & ~pd & pin_mode;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pd_prev_reg <= 1'b0;
    end else begin
      pd_prev_reg <= pd;
    end
  end

  // Serial-port pins are passed to the serial engine only while the port is enabled
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      SERIAL_DATA_O   <= 1'b0;
      SERIAL_CLK_O    <= 1'b0;
      SERIAL_SELECT_O <= 1'b1;
    end else begin
      SERIAL_DATA_O   <= pin_mode ? 1'b0 : pin_reg[2];
      SERIAL_CLK_O    <= pin_mode ? 1'b0 : pin_reg[3];
      SERIAL_SELECT_O <= pin_mode ? 1'b1 : pin_reg[4];
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  logic        dp_write_reg;
  logic [7:0]  dp_addr_reg;
  logic        addr_ok;
  logic [31:0] ctrl_reg;
  logic [`ADC_IRQ_WIDTH-1:0] irq_status_reg;
  logic [`ADC_IRQ_WIDTH-1:0] irq_mask_reg;
  logic [`ADC_IRQ_WIDTH-1:0] irq_set;
  logic [`ADC_IRQ_WIDTH-1:0] irq_clr;
  logic [31:0] status_word;
  logic [31:0] rdata_next;
  assign addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;

  // Effective configuration: registers in serial mode, straps in pin mode
  dual_adc_pkg::fmt_t  fmt;
  dual_adc_pkg::div_t  div;
  dual_adc_pkg::mode_t mode;
  assign fmt  = pin_mode ? dual_adc_pkg::fmt_t'(strap(pin_reg[2], pin_reg[5]))
                         : dual_adc_pkg::fmt_t'(ctrl_reg[`ADC_CTRL_FMT_LSB +: 2]);
  assign div  = pin_mode ? dual_adc_pkg::div_t'(strap(pin_reg[3], pin_reg[6]))
                         : dual_adc_pkg::div_t'(ctrl_reg[`ADC_CTRL_DIV_LSB +: 2]);
  assign mode = pin_mode ? dual_adc_pkg::mode_t'(strap(pin_reg[4], pin_reg[7]))
                         : dual_adc_pkg::mode_t'(ctrl_reg[`ADC_CTRL_MODE_LSB +: 2]);

  always_comb begin
    status_word = '0;
    status_word[`ADC_ST_PINMODE_BIT]     = pin_mode;
    status_word[`ADC_ST_PD_BIT]          = pd;
    status_word[`ADC_ST_FMT_LSB +: 2]    = fmt;
    status_word[`ADC_ST_DIV_LSB +: 2]    = div;
    status_word[`ADC_ST_MODE_LSB +: 2]   = mode;
    unique case (HADDR_I[7:0])
      `ADC_OFS_CTRL:       rdata_next = ctrl_reg;
      `ADC_OFS_STATUS:     rdata_next = status_word;
      `ADC_OFS_IRQ_STATUS: rdata_next = {29'h0, irq_status_reg};
      `ADC_OFS_IRQ_MASK:   rdata_next = {29'h0, irq_mask_reg};
      default:             rdata_next = '0;
    endcase
    if (|HADDR_I[31:8]) begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
      HRDATA_O     <= '0;
      HREADYOUT_O  <= 1'b1;
      HRESP_O      <= 1'b0;
    end else begin
      dp_write_reg <= addr_ok & HWRITE_I & ~(|HADDR_I[31:8]);
      dp_addr_reg  <= HADDR_I[7:0];
      HRDATA_O     <= (addr_ok & ~HWRITE_I) ? rdata_next : '0;
      HREADYOUT_O  <= 1'b1;
      HRESP_O      <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ctrl_reg <= `ADC_CTRL_RESET;
    end else if (pd_fall) begin
      ctrl_reg <= `ADC_CTRL_RESET;
    end else if (dp_write_reg && dp_addr_reg == `ADC_OFS_CTRL) begin
      ctrl_reg <= {26'h0, HWDATA_I[5:0]};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      irq_mask_reg <= '0;
    end else if (dp_write_reg && dp_addr_reg == `ADC_OFS_IRQ_MASK) begin
      irq_mask_reg <= HWDATA_I[`ADC_IRQ_WIDTH-1:0];
    end
  end

  // Conversion timing: half-cycle ticks from the selected divider
  logic [2:0] div_cnt_reg;
  logic       half_tick;
  logic       phase_reg;
  assign half_tick = ~pd & (div_cnt_reg >= half_len(div) - 3'h1);

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || pd) begin
      div_cnt_reg <= 3'h0;
      phase_reg   <= 1'b0;
    end else if (half_tick) begin
      div_cnt_reg <= 3'h0;
      phase_reg   <= ~phase_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end

  // Sample held over both halves; delay line shifts each half for nine full cycles
  logic [DW-1:0] sample_hold_reg;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sample_hold_reg <= '0;
    end else if (half_tick && !phase_reg) begin
      sample_hold_reg <= {CORE_OVERRANGE_B_I, CORE_SAMPLE_B_I, CORE_OVERRANGE_A_I, CORE_SAMPLE_A_I};
    end
  end

  delay_if #(.W(DW)) dl ();
  assign dl.shift = half_tick;
  assign dl.din   = (half_tick && !phase_reg)
                  ? {CORE_OVERRANGE_B_I, CORE_SAMPLE_B_I, CORE_OVERRANGE_A_I, CORE_SAMPLE_A_I}
                  : sample_hold_reg;

  half_step_delay #(.DEPTH(`ADC_HALF_STEPS), .W(DW)) u_delay (
    .CLK_I   (CLK_I),
    .RST_N_I (RST_N_I),
    .dl      (dl)
  );

  logic [SW-1:0] word_a;
  logic [SW-1:0] word_b;
  logic          ovr_a;
  logic          ovr_b;
  assign word_a = recode(dl.dout[SW-1:0], fmt);
  assign ovr_a  = dl.dout[SW];
  assign word_b = recode(dl.dout[2*SW:SW+1], fmt);
  assign ovr_b  = dl.dout[DW-1];

  // Output buses, flags and data clocks
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || pd) begin
      SAMPLE_A_O         <= '0;
      SAMPLE_B_O         <= '0;
      SAMPLE_A_OE_O      <= 1'b0;
      SAMPLE_B_OE_O      <= 1'b0;
      OVERRANGE_FLAG_A_O <= 1'b0;
      OVERRANGE_FLAG_B_O <= 1'b0;
      DATA_CLOCK_OUT_A_O <= 1'b0;
      DATA_CLOCK_OUT_B_O <= 1'b0;
    end else if (half_tick) begin
      SAMPLE_A_OE_O <= (mode != dual_adc_pkg::MODE_MUX_B);
      SAMPLE_B_OE_O <= (mode != dual_adc_pkg::MODE_MUX_A);
      unique case (mode)
        dual_adc_pkg::MODE_DUAL: begin
          if (!phase_reg) begin
            SAMPLE_A_O         <= word_a;
            SAMPLE_B_O         <= word_b;
            OVERRANGE_FLAG_A_O <= ovr_a;
            OVERRANGE_FLAG_B_O <= ovr_b;
          end
          DATA_CLOCK_OUT_A_O <= phase_reg;
          DATA_CLOCK_OUT_B_O <= phase_reg;
        end
        dual_adc_pkg::MODE_MUX_A: begin
          SAMPLE_A_O         <= phase_reg ? word_b : word_a;
          OVERRANGE_FLAG_A_O <= phase_reg ? ovr_b : ovr_a;
          DATA_CLOCK_OUT_A_O <= phase_reg;
          SAMPLE_B_O         <= '0;
          OVERRANGE_FLAG_B_O <= 1'b0;
          DATA_CLOCK_OUT_B_O <= 1'b0;
        end
        default: begin
          SAMPLE_B_O         <= phase_reg ? word_b : word_a;
          OVERRANGE_FLAG_B_O <= phase_reg ? ovr_b : ovr_a;
          DATA_CLOCK_OUT_B_O <= phase_reg;
          SAMPLE_A_O         <= '0;
          OVERRANGE_FLAG_A_O <= 1'b0;
          DATA_CLOCK_OUT_A_O <= 1'b0;
        end
      endcase
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  always_comb begin
    irq_set = '0;
    irq_set[`ADC_IRQ_CFGRST_BIT] = pd_fall;
    irq_set[`ADC_IRQ_OVRA_BIT]   = half_tick & ~phase_reg & ovr_a;
    irq_set[`ADC_IRQ_OVRB_BIT]   = half_tick & ~phase_reg & ovr_b;
    irq_clr = (dp_write_reg && dp_addr_reg == `ADC_OFS_IRQ_STATUS) ? HWDATA_I[`ADC_IRQ_WIDTH-1:0] : '0;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      irq_status_reg <= '0;
      IRQ_O          <= 1'b0;
      POWERED_DOWN_O <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      IRQ_O          <= |(irq_status_reg & irq_mask_reg);
      POWERED_DOWN_O <= pd;
    end
  end
endmodule : dual_adc_ctrl
`default_nettype wire

/* verification/dual_adc_assertions.sv */
// Port checks for dual_adc_ctrl, bound to every instance.
// Assumes one clock CLK_I with sync active-low reset.
`timescale 1ns/100ps
`default_nettype none
module dual_adc_checker (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic        SERIAL_PORT_ENABLE_N_I,
  input wire logic        POWER_DOWN_PIN_I,
  input wire logic [9:0]  SAMPLE_A_O,
  input wire logic        SAMPLE_A_OE_O,
  input wire logic        OVERRANGE_FLAG_A_O,
  input wire logic        DATA_CLOCK_OUT_A_O,
  input wire logic [9:0]  SAMPLE_B_O,
  input wire logic        SAMPLE_B_OE_O,
  input wire logic        DATA_CLOCK_OUT_B_O,
  input wire logic        SERIAL_CLK_O,
  input wire logic        SERIAL_SELECT_O,
  input wire logic        POWERED_DOWN_O,
  input wire logic        HSEL_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O
);
  logic rd_req_reg;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Read taken in the previous cycle
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rd_req_reg <= 1'b0;
    end else begin
      rd_req_reg <= HSEL_I & HTRANS_I[1] & ~HWRITE_I & HREADY_I;
    end
  end
  a_pd_enter: assert property (POWER_DOWN_PIN_I [*7] |-> POWERED_DOWN_O)
    else $error("power-down not entered");
  a_pd_leave: assert property ((!POWER_DOWN_PIN_I) [*7] |-> !POWERED_DOWN_O)
    else $error("power-down not left");
  a_pd_quiet: assert property (POWERED_DOWN_O && $past(POWERED_DOWN_O) |->
      !(SAMPLE_A_OE_O | SAMPLE_B_OE_O | DATA_CLOCK_OUT_A_O | DATA_CLOCK_OUT_B_O))
    else $error("outputs active in power-down");
  a_strap_idle: assert property (SERIAL_PORT_ENABLE_N_I [*7] |->
      SERIAL_SELECT_O && !SERIAL_CLK_O)
    else $error("serial pins active in strap mode");
  a_dual_hold: assert property (SAMPLE_A_OE_O && SAMPLE_B_OE_O && $past(SAMPLE_B_OE_O)
      && $rose(DATA_CLOCK_OUT_A_O) |-> $stable(SAMPLE_A_O) && $stable(OVERRANGE_FLAG_A_O))
    else $error("word moved at data clock rise");
  a_mux_quiet: assert property (SAMPLE_A_OE_O && !SAMPLE_B_OE_O && !$past(SAMPLE_B_OE_O)
      |-> SAMPLE_B_O == 10'h000)
    else $error("idle bus not zero");
  a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus response not ready okay");
  a_rdata_idle: assert property (!rd_req_reg |-> HRDATA_O == 32'h0000_0000)
    else $error("read data without read");
endmodule : dual_adc_checker
bind dual_adc_ctrl dual_adc_checker chk_u (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .SERIAL_PORT_ENABLE_N_I(SERIAL_PORT_ENABLE_N_I),
  .POWER_DOWN_PIN_I(POWER_DOWN_PIN_I), .SAMPLE_A_O(SAMPLE_A_O), .SAMPLE_A_OE_O(SAMPLE_A_OE_O),
  .OVERRANGE_FLAG_A_O(OVERRANGE_FLAG_A_O), .DATA_CLOCK_OUT_A_O(DATA_CLOCK_OUT_A_O),
  .SAMPLE_B_O(SAMPLE_B_O), .SAMPLE_B_OE_O(SAMPLE_B_OE_O), .DATA_CLOCK_OUT_B_O(DATA_CLOCK_OUT_B_O),
  .SERIAL_CLK_O(SERIAL_CLK_O), .SERIAL_SELECT_O(SERIAL_SELECT_O), .POWERED_DOWN_O(POWERED_DOWN_O),
  .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
  .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O));
`default_nettype wire

/* verification/capture_lane.sv */
// Receiver model for one channel: takes word and flag on data clock rise.
// Assumes a three-state bus; undriven lines show the inverse of the drive.
`timescale 1ns/100ps
`default_nettype none
module capture_lane (
  input  wire logic       dclk_i,
  input  wire logic [9:0] word_i,
  input  wire logic       oe_i,
  input  wire logic       flag_i,
  output logic      [9:0] word_o,
  output logic            flag_o
);
  always_ff @(posedge dclk_i) begin
    word_o <= oe_i ? word_i : ~word_i;
    flag_o <= flag_i;
  end
endmodule : capture_lane
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for dual_adc_ctrl with an AHB-Lite master.
// Assumes the bound checker and two capture_lane receivers.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [5:0] p; logic [9:0] ea, eb; logic [7:0] st; logic [1:0] oe;} row_t;
  logic        clk, rst_n, serial_port_enable_n_n, pd, oa, ob, hsel, hwrite;
  logic [5:0]  pins;
  logic [9:0]  ca, cb, sa, sb, wa, wb;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        sa_oe, sb_oe, fa, fb, dka, dkb, sdo, sco, sso, pdo, irq, hrdy, hresp, ga, gb;
  int          n_errors, check_count, lat;
  // Strap pins {fmt, fmt float, div, div float, mode, mode float}
  row_t rows [5] = '{'{6'h00, 10'h0a5, 10'h35a, 8'h01, 2'h3}, '{6'h28, 10'h2a5, 10'h15a, 8'h15, 2'h3},
    '{6'h14, 10'h3f7, 10'h1f7, 8'h29, 2'h3}, '{6'h02, 10'h0a5, 10'h35a, 8'h41, 2'h2},
    '{6'h01, 10'h0a5, 10'h35a, 8'h81, 2'h1}};
  dual_adc_ctrl dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .SERIAL_PORT_ENABLE_N_I(serial_port_enable_n_n), .POWER_DOWN_PIN_I(pd),
    .SERIAL_IN_OR_FORMAT_PIN_I(pins[5]), .SERIAL_IN_OR_FORMAT_FLOAT_I(pins[4]),
    .SERIAL_CLK_OR_DIVIDER_PIN_I(pins[3]), .SERIAL_CLK_OR_DIVIDER_FLOAT_I(pins[2]),
    .PORT_SELECT_OR_OUTPUT_MODE_PIN_I(pins[1]), .PORT_SELECT_OR_OUTPUT_MODE_FLOAT_I(pins[0]),
    .CORE_SAMPLE_A_I(ca), .CORE_OVERRANGE_A_I(oa), .CORE_SAMPLE_B_I(cb), .CORE_OVERRANGE_B_I(ob),
    .SAMPLE_A_O(sa), .SAMPLE_A_OE_O(sa_oe), .OVERRANGE_FLAG_A_O(fa), .DATA_CLOCK_OUT_A_O(dka),
    .SAMPLE_B_O(sb), .SAMPLE_B_OE_O(sb_oe), .OVERRANGE_FLAG_B_O(fb), .DATA_CLOCK_OUT_B_O(dkb),
    .SERIAL_DATA_O(sdo), .SERIAL_CLK_O(sco), .SERIAL_SELECT_O(sso), .POWERED_DOWN_O(pdo),
    .IRQ_O(irq), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy),
    .HRESP_O(hresp));
  capture_lane lane_a (.dclk_i(dka), .word_i(sa), .oe_i(sa_oe), .flag_i(fa), .word_o(wa), .flag_o(ga));
  capture_lane lane_b (.dclk_i(dkb), .word_i(sb), .oe_i(sb_oe), .flag_i(fb), .word_o(wb), .flag_o(gb));
  task stop_test;
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task chk(input string name, input logic [31:0] exp_v, input logic [31:0] got_v);
    check_count++;
    if (got_v !== exp_v) begin
      $display("ERROR %s expected %h seen %h", name, exp_v, got_v);
      n_errors++;
    end
  endtask : chk
  task wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hrdy !== 1'b1 && i < 50);
    if (hrdy !== 1'b1) begin
      n_errors++;
      stop_test();
    end
  endtask : wait_rdy
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rdv = hrdata;
  endtask : ahb
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  initial begin
    {rst_n, serial_port_enable_n_n, pd, oa, ob, hsel, hwrite, pins, htrans} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'h2;
    oa = 1'b1;
    ca = 10'h2a5;
    cb = 10'h15a;
    repeat (10) @(posedge clk);
    chk("reset", 32'h3, {27'h0, sa_oe, sb_oe, irq, sso, hrdy});
    rst_n <= 1'b1;
    serial_port_enable_n_n <= 1'b1;
    foreach (rows[i]) begin
      pins <= rows[i].p;
      repeat (200) @(posedge clk);
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk("status", {24'h0, rows[i].st}, rd);
      chk("bus_oe", {30'h0, rows[i].oe}, {30'h0, sa_oe, sb_oe});
      if (rows[i].oe == 2'h3) begin
        chk("word_a", {22'h0, rows[i].ea}, {22'h0, wa});
        chk("word_b", {22'h0, rows[i].eb}, {22'h0, wb});
        chk("flags", 32'h2, {30'h0, ga, gb});
      end else begin
        #1;
        chk("mux_word", (dka | dkb) ? {22'h0, rows[i].eb} : {22'h0, rows[i].ea}, {22'h0, sa | sb});
        chk("mux_flag", {31'h0, ~(dka | dkb)}, {31'h0, fa | fb});
        @(posedge clk);
      end
    end
    pins <= 6'h20;
    repeat (60) @(posedge clk);
    ca <= 10'h0f0;
    for (lat = 1; lat < 40; lat++) begin
      @(posedge clk);
      #1;
      if (sa === 10'h0f0) break;
    end
    chk("latency", 32'h1, {31'h0, lat >= 19 && lat <= 22});
    ahb(1'b1, 8'h0c, 32'h0, rd);
    repeat (3) @(posedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    ahb(1'b1, 8'h0c, 32'h2, rd);
    repeat (3) @(posedge clk);
    chk("irq_ovr", 32'h1, {31'h0, irq});
    oa <= 1'b0;
    repeat (60) @(posedge clk);
    ahb(1'b1, 8'h08, 32'h2, rd);
    repeat (3) @(posedge clk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    serial_port_enable_n_n <= 1'b0;
    pins <= 6'h28;
    repeat (10) @(posedge clk);
    chk("serial_fwd", 32'h6, {29'h0, sdo, sco, sso});
    ahb(1'b1, 8'h00, 32'h2a, rd);
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk("ctrl", 32'h2a, rd);
    ahb(1'b1, 8'h00, 32'h02, rd);
    repeat (100) @(posedge clk);
    chk("gray_word", 32'h088, {22'h0, wa});
    ahb(1'b1, 8'h0c, 32'h1, rd);
    serial_port_enable_n_n <= 1'b1;
    pd <= 1'b1;
    repeat (20) @(posedge clk);
    chk("pd_outs", 32'h8, {28'h0, pdo, sa_oe, sb_oe, dka});
    pd <= 1'b0;
    repeat (20) @(posedge clk);
    serial_port_enable_n_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("irq_cfg", 32'h1, {31'h0, irq});
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk("ctrl_rst", 32'h0, rd);
    ahb(1'b1, 8'h08, 32'h1, rd);
    repeat (3) @(posedge clk);
    chk("irq_cfg_clr", 32'h0, {31'h0, irq});
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
